// ===== port_pkg.sv
/*
  shared constants of the banked general-purpose port block.
  assumes a 4-bit data path and a 7-bit data memory address with bank.
*/
package port_pkg;
  localparam int unsigned NIBBLE = 4;
  localparam logic [6:0] ADDR_PORT_70 = 7'h70;
  localparam logic [6:0] ADDR_PORT_71 = 7'h71;
  localparam logic [6:0] ADDR_PORT_72 = 7'h72;
  localparam logic [6:0] ADDR_PORT_73 = 7'h73;
  localparam logic [5:0] RF_DIR_T = 6'h27;
  localparam logic [5:0] RF_DIR_U = 6'h35;
  localparam logic [5:0] RF_DIR_X = 6'h36;
  localparam logic [5:0] RF_DIR_W = 6'h37;
  localparam logic [1:0] BANK_ZERO = 2'h0;
  localparam logic [1:0] BANK_ONE = 2'h1;
  localparam logic [1:0] BANK_TWO = 2'h2;
  localparam logic [3:0] DIR_ALL_INPUT = 4'h0;
  localparam logic [3:0] GROUP_PIN_MASK = 4'hE;
  localparam int unsigned GROUP_DIR_BIT = 0;
endpackage

// ===== pin_sync.sv
/*
  two flip-flop synchroniser for a bus of pin levels.
  assumes the pins are asynchronous to clk_sys_in.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      stage_one <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule
`default_nettype wire

// ===== port_latch.sv
/*
  one 4-bit output latch with write enable.
  assumes write strobes come from the same clock; power-on reset clears.
*/
`timescale 1ns/1ps
`default_nettype none
module port_latch #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic clk_sys_in,
  input wire logic por_in,
  input wire logic write_in,
  input wire logic [WIDTH-1:0] data_in,
  output logic [WIDTH-1:0] latch_out
);
  // power-on only; ce reset leaves the latch alone
  always_ff @(posedge clk_sys_in or posedge por_in)
  begin
    if (por_in)
      latch_out <= '0;
    else if (write_in)
      latch_out <= data_in;
  end
endmodule
`default_nettype wire

// ===== banked_general_purpose_ports.sv
/*
  banked general-purpose ports: seven 4-bit ports in data memory 70H-73H
  and four direction registers in the control register file.
  assumes a core that gives one-cycle read/write strobes with bank, address
  and nibble data; reset_in is power-on reset, ce_reset_in and clock_stop_in
  are synchronous level inputs from the core.
*/
`timescale 1ns/1ps
`default_nettype none
// How it works
// - port registers occupy data addresses 70H-73H
// - bank zero and bank two alias ports
// - bit ports per pin, group port together
// - output pins drive written latch value
// - input pins read back pin level
// - direction registers steer pin directions
// - all ports general purpose after reset
// - ports act as ordinary data memory
// - w,x,u directions at 37H,36H,35H
// - group port direction at 27H
// - w at 70H, x at 71H, banks 0/2
// - u at 71H, t at 72H, bank 1
// - input port z read at 73H
// - y at 72H banks 0/2, v 70H data_bank_one
// - group port bit 0 reads zero
// - write updates latch, read shows latch for output bits, pin for input bits
// - input pin writes still update latch
// - resets and clock stop force inputs
// - ce reset keeps output latches
// - output-only ports read back latch
module banked_general_purpose_ports (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic ce_reset_in,
  input wire logic clock_stop_in,
  input wire logic [1:0] bank_in,
  input wire logic [6:0] mem_addr_in,
  input wire logic mem_write_in,
  input wire logic mem_read_in,
  input wire logic [3:0] mem_wdata_in,
  output logic [3:0] mem_rdata_out,
  output logic mem_hit_out,
  input wire logic [5:0] rf_addr_in,
  input wire logic rf_write_in,
  input wire logic rf_read_in,
  input wire logic [3:0] rf_wdata_in,
  output logic [3:0] rf_rdata_out,
  output logic rf_hit_out,
  input wire logic [3:0] bidir_port_w_in,
  output logic [3:0] bidir_port_w_out,
  output logic [3:0] bidir_port_w_oe_n_out,
  input wire logic [3:0] bidir_port_x_in,
  output logic [3:0] bidir_port_x_out,
  output logic [3:0] bidir_port_x_oe_n_out,
  input wire logic [3:0] bidir_port_u_in,
  output logic [3:0] bidir_port_u_out,
  output logic [3:0] bidir_port_u_oe_n_out,
  input wire logic [3:0] group_port_t_in,
  output logic [3:0] group_port_t_out,
  output logic [3:0] group_port_t_oe_n_out,
  input wire logic [3:0] input_port_z_in,
  output logic [3:0] output_port_y_out,
  output logic [3:0] output_port_v_out
);
  // ==========================================================
  // decode
  function automatic logic bank_is_even(input logic [1:0] bank);
    bank_is_even = (bank == port_pkg::BANK_ZERO) ||
      (bank == port_pkg::BANK_TWO);
  endfunction

  wire logic even_bank = bank_is_even(bank_in);
  wire logic odd_bank = (bank_in == port_pkg::BANK_ONE);
  wire logic sel_w = even_bank && (mem_addr_in == port_pkg::ADDR_PORT_70);
  wire logic sel_x = even_bank && (mem_addr_in == port_pkg::ADDR_PORT_71);
  wire logic sel_y = even_bank && (mem_addr_in == port_pkg::ADDR_PORT_72);
  wire logic sel_z = even_bank && (mem_addr_in == port_pkg::ADDR_PORT_73);
  wire logic sel_v = odd_bank && (mem_addr_in == port_pkg::ADDR_PORT_70);
  wire logic sel_u = odd_bank && (mem_addr_in == port_pkg::ADDR_PORT_71);
  wire logic sel_t = odd_bank && (mem_addr_in == port_pkg::ADDR_PORT_72);
  wire logic any_sel = sel_w | sel_x | sel_y | sel_z | sel_v | sel_u |
    sel_t;
  wire logic rf_w = (rf_addr_in == port_pkg::RF_DIR_W);
  wire logic rf_x = (rf_addr_in == port_pkg::RF_DIR_X);
  wire logic rf_u = (rf_addr_in == port_pkg::RF_DIR_U);
  wire logic rf_t = (rf_addr_in == port_pkg::RF_DIR_T);
  wire logic rf_any = rf_w | rf_x | rf_u | rf_t;

  // ==========================================================
  // direction registers (1 = output)
  logic [3:0] dir_select_w;
  logic [3:0] dir_select_x;
  logic [3:0] dir_select_u;
  logic [3:0] dir_select_t;
  wire logic force_input = ce_reset_in | clock_stop_in;

  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      dir_select_w <= port_pkg::DIR_ALL_INPUT;
      dir_select_x <= port_pkg::DIR_ALL_INPUT;
      dir_select_u <= port_pkg::DIR_ALL_INPUT;
      dir_select_t <= port_pkg::DIR_ALL_INPUT;
    end
    else if (force_input)
    begin
      dir_select_w <= port_pkg::DIR_ALL_INPUT;
      dir_select_x <= port_pkg::DIR_ALL_INPUT;
      dir_select_u <= port_pkg::DIR_ALL_INPUT;
      dir_select_t <= port_pkg::DIR_ALL_INPUT;
    end
    else if (rf_write_in)
    begin
      if (rf_w)
        dir_select_w <= rf_wdata_in;
      if (rf_x)
        dir_select_x <= rf_wdata_in;
      if (rf_u)
        dir_select_u <= rf_wdata_in;
      if (rf_t)
        dir_select_t <= rf_wdata_in;
    end
  end

  // group port: one direction bit covers its three pins
  wire logic group_out = dir_select_t[port_pkg::GROUP_DIR_BIT];
  wire logic [3:0] dir_t_pins = group_out ? port_pkg::GROUP_PIN_MASK :
    port_pkg::DIR_ALL_INPUT;

  // ==========================================================
  // output latches, kept across ce reset
  logic [3:0] latch_w;
  logic [3:0] latch_x;
  logic [3:0] latch_u;
  logic [3:0] latch_t;
  logic [3:0] latch_y;
  logic [3:0] latch_v;
  // writes land regardless of direction
  wire logic wr_w = mem_write_in & sel_w;
  wire logic wr_x = mem_write_in & sel_x;
  wire logic wr_u = mem_write_in & sel_u;
  wire logic wr_t = mem_write_in & sel_t;
  wire logic wr_y = mem_write_in & sel_y;
  wire logic wr_v = mem_write_in & sel_v;
  wire logic [3:0] wdata_t = mem_wdata_in & port_pkg::GROUP_PIN_MASK;

  port_latch #(.WIDTH(port_pkg::NIBBLE)) u_lat_w (.clk_sys_in(clk_sys_in),
    .por_in(reset_in), .write_in(wr_w), .data_in(mem_wdata_in),
    .latch_out(latch_w));
  port_latch #(.WIDTH(port_pkg::NIBBLE)) u_lat_x (.clk_sys_in(clk_sys_in),
    .por_in(reset_in), .write_in(wr_x), .data_in(mem_wdata_in),
    .latch_out(latch_x));
  port_latch #(.WIDTH(port_pkg::NIBBLE)) u_lat_u (.clk_sys_in(clk_sys_in),
    .por_in(reset_in), .write_in(wr_u), .data_in(mem_wdata_in),
    .latch_out(latch_u));
  port_latch #(.WIDTH(port_pkg::NIBBLE)) u_lat_t (.clk_sys_in(clk_sys_in),
    .por_in(reset_in), .write_in(wr_t), .data_in(wdata_t),
    .latch_out(latch_t));
  port_latch #(.WIDTH(port_pkg::NIBBLE)) u_lat_y (.clk_sys_in(clk_sys_in),
    .por_in(reset_in), .write_in(wr_y), .data_in(mem_wdata_in),
    .latch_out(latch_y));
  port_latch #(.WIDTH(port_pkg::NIBBLE)) u_lat_v (.clk_sys_in(clk_sys_in),
    .por_in(reset_in), .write_in(wr_v), .data_in(mem_wdata_in),
    .latch_out(latch_v));
  // no latch for the input port: writes there are dropped

  // ==========================================================
  // pin synchronisers
  logic [3:0] pin_w;
  logic [3:0] pin_x;
  logic [3:0] pin_u;
  logic [3:0] pin_t;
  logic [3:0] pin_z;
  pin_sync #(.WIDTH(port_pkg::NIBBLE)) u_sync_w (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .async_in(bidir_port_w_in), .sync_out(pin_w));
  pin_sync #(.WIDTH(port_pkg::NIBBLE)) u_sync_x (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .async_in(bidir_port_x_in), .sync_out(pin_x));
  pin_sync #(.WIDTH(port_pkg::NIBBLE)) u_sync_u (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .async_in(bidir_port_u_in), .sync_out(pin_u));
  pin_sync #(.WIDTH(port_pkg::NIBBLE)) u_sync_t (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .async_in(group_port_t_in), .sync_out(pin_t));
  pin_sync #(.WIDTH(port_pkg::NIBBLE)) u_sync_z (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .async_in(input_port_z_in), .sync_out(pin_z));

  // ==========================================================
  // read mux: output bits show latch, input bits show pin
  function automatic logic [3:0] mix(input logic [3:0] dir,
    input logic [3:0] latch, input logic [3:0] pin);
    mix = (dir & latch) | (~dir & pin);
  endfunction

  wire logic [3:0] read_w = mix(dir_select_w, latch_w, pin_w);
  wire logic [3:0] read_x = mix(dir_select_x, latch_x, pin_x);
  wire logic [3:0] read_u = mix(dir_select_u, latch_u, pin_u);
  wire logic [3:0] read_t = mix(dir_t_pins, latch_t, pin_t) &
    port_pkg::GROUP_PIN_MASK;
  wire logic [3:0] port_rd = sel_w ? read_w : sel_x ? read_x :
    sel_u ? read_u : sel_t ? read_t : sel_z ? pin_z :
    sel_y ? latch_y : sel_v ? latch_v : 4'h0;
  wire logic [3:0] rf_rd = rf_w ? dir_select_w : rf_x ? dir_select_x :
    rf_u ? dir_select_u : rf_t ? dir_select_t : 4'h0;

  // read data sampled on the read strobe
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      mem_rdata_out <= 4'h0;
      rf_rdata_out <= 4'h0;
    end
    else
    begin
      if (mem_read_in)
        mem_rdata_out <= port_rd;
      if (rf_read_in)
        rf_rdata_out <= rf_rd;
    end
  end
  assign mem_hit_out = any_sel;
  assign rf_hit_out = rf_any;

  // ==========================================================
  // pins: bit n of each register is pin n
  assign bidir_port_w_out = latch_w;
  assign bidir_port_x_out = latch_x;
  assign bidir_port_u_out = latch_u;
  assign group_port_t_out = latch_t;
  assign bidir_port_w_oe_n_out = ~dir_select_w;
  assign bidir_port_x_oe_n_out = ~dir_select_x;
  assign bidir_port_u_oe_n_out = ~dir_select_u;
  assign group_port_t_oe_n_out = ~dir_t_pins;
  assign output_port_y_out = latch_y;
  assign output_port_v_out = latch_v;

  // ==========================================================
  // checks
  property p_force_in;
    @(posedge clk_sys_in) disable iff (reset_in)
    force_input |=> (bidir_port_w_oe_n_out == 4'hF) &&
      (group_port_t_oe_n_out == 4'hF);
  endproperty
  a_force_in: assert property (p_force_in)
    else $error("pins not input after ce reset or clock stop");

  property p_latch_kept;
    @(posedge clk_sys_in) disable iff (reset_in)
    ce_reset_in && !wr_w |=> latch_w == $past(latch_w);
  endproperty
  a_latch_kept: assert property (p_latch_kept)
    else $error("latch changed on ce reset");

  property p_t_bit0;
    @(posedge clk_sys_in) disable iff (reset_in)
    mem_read_in && sel_t |=> mem_rdata_out[0] == 1'b0;
  endproperty
  a_t_bit0: assert property (p_t_bit0)
    else $error("group port bit 0 read nonzero");

  property p_write_w;
    @(posedge clk_sys_in) disable iff (reset_in)
    wr_w |=> latch_w == $past(mem_wdata_in);
  endproperty
  a_write_w: assert property (p_write_w)
    else $error("port w latch not updated");

  property p_alias;
    @(posedge clk_sys_in) disable iff (reset_in)
    mem_write_in && mem_addr_in == port_pkg::ADDR_PORT_71 &&
      bank_in == port_pkg::BANK_TWO |=> latch_x == $past(mem_wdata_in);
  endproperty
  a_alias: assert property (p_alias)
    else $error("bank two does not reach port x");

  property p_drive;
    @(posedge clk_sys_in) disable iff (reset_in)
    (dir_select_x == 4'hF) |-> bidir_port_x_oe_n_out == 4'h0 &&
      bidir_port_x_out == latch_x;
  endproperty
  a_drive: assert property (p_drive)
    else $error("output pin not driving latch");

  property p_rd_y;
    @(posedge clk_sys_in) disable iff (reset_in)
    mem_read_in && sel_y |=> mem_rdata_out == $past(latch_y);
  endproperty
  a_rd_y: assert property (p_rd_y)
    else $error("output port read not latch");

  property p_rd_z;
    @(posedge clk_sys_in) disable iff (reset_in)
    mem_read_in && sel_z |=> mem_rdata_out == $past(pin_z);
  endproperty
  a_rd_z: assert property (p_rd_z)
    else $error("input port read wrong");

  property p_dir_wr;
    @(posedge clk_sys_in) disable iff (reset_in)
    rf_write_in && rf_u && !force_input |=>
      bidir_port_u_oe_n_out == ~$past(rf_wdata_in);
  endproperty
  a_dir_wr: assert property (p_dir_wr)
    else $error("direction write not applied");
endmodule
`default_nettype wire

// ===== pin_partner.sv
/*
  external circuits on the bidirectional port pins, one wire per pin.
  assumes oe_n low means the block drives the pin; else outside drives it.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input wire logic [15:0] ext_in,
  input wire logic [15:0] drv_in,
  input wire logic [15:0] oe_n_in,
  output logic [15:0] wire_out
);
  // driven pins show the block level, released pins the outside level
  assign wire_out = (drv_in & ~oe_n_in) | (ext_in & oe_n_in);
endmodule
`default_nettype wire

// ===== testbench.sv
/*
  self-checking bench of the banked port block with a reference model.
  assumes pin_partner resolves the pins; stimulus on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce_rst = 1'b0;
  logic stop = 1'b0;
  logic [1:0] bank = 2'h0;
  logic [6:0] addr = 7'h00;
  logic mwr = 1'b0;
  logic mrd = 1'b0;
  logic [3:0] mwd = 4'h0;
  logic [3:0] mrdat;
  logic mhit;
  logic [5:0] raddr = 6'h00;
  logic rwr = 1'b0;
  logic rrd = 1'b0;
  logic [3:0] rwd = 4'h0;
  logic [3:0] rrdat;
  logic rhit;
  logic [15:0] ext = 16'h0000;
  logic [3:0] zin = 4'h0;
  logic [15:0] drv;
  logic [15:0] oen;
  logic [15:0] pins;
  logic [3:0] y_out;
  logic [3:0] v_out;
  logic [31:0] seed = 32'h8371EC41;
  logic [31:0] r;
  int fails = 0;
  int total_checks = 0;
  int lat [7] = '{0, 0, 0, 0, 0, 0, 0};
  int dir [4] = '{0, 0, 0, 0};
  int rf_tab [4] = '{6'h37, 6'h36, 6'h35, 6'h27};

  always #20 clk = ~clk;

  banked_general_purpose_ports dut (
    .clk_sys_in(clk), .reset_in(rst), .ce_reset_in(ce_rst),
    .clock_stop_in(stop), .bank_in(bank), .mem_addr_in(addr),
    .mem_write_in(mwr), .mem_read_in(mrd), .mem_wdata_in(mwd),
    .mem_rdata_out(mrdat), .mem_hit_out(mhit), .rf_addr_in(raddr),
    .rf_write_in(rwr), .rf_read_in(rrd), .rf_wdata_in(rwd),
    .rf_rdata_out(rrdat), .rf_hit_out(rhit),
    .bidir_port_w_in(pins[3:0]), .bidir_port_w_out(drv[3:0]),
    .bidir_port_w_oe_n_out(oen[3:0]), .bidir_port_x_in(pins[7:4]),
    .bidir_port_x_out(drv[7:4]), .bidir_port_x_oe_n_out(oen[7:4]),
    .bidir_port_u_in(pins[11:8]), .bidir_port_u_out(drv[11:8]),
    .bidir_port_u_oe_n_out(oen[11:8]), .group_port_t_in(pins[15:12]),
    .group_port_t_out(drv[15:12]), .group_port_t_oe_n_out(oen[15:12]),
    .input_port_z_in(zin), .output_port_y_out(y_out),
    .output_port_v_out(v_out));

  pin_partner partner (.ext_in(ext), .drv_in(drv), .oe_n_in(oen),
    .wire_out(pins));

  // ==========================================
  // reference model and compares
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // port index 0 w,1 x,2 u,3 t,4 z,5 y,6 v; -1 unmapped
  function automatic int port_of(int b, int a);
    int t0 [4] = '{0, 1, 5, 4};
    int t1 [4] = '{6, 2, 3, -1};
    if (a < 7'h70 || a > 7'h73 || b == 3)
      return -1;
    return (b == 1) ? t1[a - 7'h70] : t0[a - 7'h70];
  endfunction

  function automatic int dir_of(int a);
    for (int q = 0; q < 4; q++)
      if (rf_tab[q] == a)
        return q;
    return -1;
  endfunction

  function automatic logic [3:0] exp_read(int p);
    logic [3:0] m;
    logic [3:0] e;
    if (p < 0)
      return 4'h0;
    m = (p == 3) ? (dir[3][0] ? 4'hE : 4'h0) :
      (p < 3) ? dir[p][3:0] : (p == 4) ? 4'h0 : 4'hF;
    e = (p < 4) ? ext[4*p +: 4] : zin;
    if (p == 3)
      e = e & 4'hE;
    return (lat[p][3:0] & m) | (e & ~m);
  endfunction

  task automatic chk_nib(string name, logic [3:0] got, logic [3:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(string name, logic got, logic exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic check_pins();
    logic [3:0] e;
    for (int p = 0; p < 4; p++)
    begin
      e = (p < 3) ? ~dir[p][3:0] : (dir[3][0] ? 4'h1 : 4'hF);
      chk_nib("oe_n", oen[4*p +: 4], e);
      chk_nib("pin_out", drv[4*p +: 4], lat[p][3:0]);
    end
    chk_nib("port_y", y_out, lat[5][3:0]);
    chk_nib("port_v", v_out, lat[6][3:0]);
  endtask

  // ==========================================
  // bus tasks, entered on a falling edge
  task automatic mem_op(logic wr, int b, int a, logic [3:0] d);
    int p;
    p = port_of(b, a);
    bank = b[1:0];
    addr = a[6:0];
    mwd = d;
    mwr = wr;
    mrd = ~wr;
    #1 chk_bit("mem_hit", mhit, p >= 0);
    @(negedge clk);
    mwr = 1'b0;
    mrd = 1'b0;
    if (!wr)
      chk_nib("mem_rdata", mrdat, exp_read(p));
    else if (p >= 0 && p != 4)
      lat[p] = (p == 3) ? d & 4'hE : d;
    @(negedge clk);
  endtask

  task automatic rf_op(logic wr, int a, logic [3:0] d);
    int q;
    q = dir_of(a);
    raddr = a[5:0];
    rwd = d;
    rwr = wr;
    rrd = ~wr;
    #1 chk_bit("rf_hit", rhit, q >= 0);
    @(negedge clk);
    rwr = 1'b0;
    rrd = 1'b0;
    if (!wr)
      chk_nib("rf_rdata", rrdat, (q >= 0) ? dir[q][3:0] : 4'h0);
    else if (q >= 0 && !(ce_rst || stop))
      dir[q] = d;
    @(negedge clk);
  endtask

  task automatic close_out();
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #(40 * 20000);
    fails++;
    close_out();
  end

  // ==========================================
  // main sequence
  initial
  begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    // group pins high, bit 0 included, so the empty bit is really tried
    ext = 16'hF000;
    check_pins();
    for (int q = 0; q < 4; q++)
      rf_op(1'b0, rf_tab[q], 4'h0);
    mem_op(1'b1, 0, 7'h72, 4'hF);
    mem_op(1'b0, 2, 7'h72, 4'h0);
    mem_op(1'b1, 1, 7'h72, 4'hF);
    mem_op(1'b0, 1, 7'h72, 4'h0);
    for (int k = 0; k < 2; k++)
    begin
      for (int q = 0; q < 4; q++)
        rf_op(1'b1, rf_tab[q], 4'hF);
      mem_op(1'b1, 0, 7'h70, 4'h9);
      check_pins();
      ce_rst = (k == 0);
      stop = (k == 1);
      for (int q = 0; q < 4; q++)
        dir[q] = 0;
      @(negedge clk);
      rf_op(1'b1, rf_tab[0], 4'h5);
      check_pins();
      ce_rst = 1'b0;
      stop = 1'b0;
      @(negedge clk);
      for (int q = 0; q < 4; q++)
        rf_op(1'b0, rf_tab[q], 4'h0);
    end
    for (int i = 0; i < 400; i++)
    begin
      r = rnd();
      ext = r[15:0];
      zin = r[19:16];
      repeat (4) @(negedge clk);
      r = rnd();
      mem_op(1'b0, r[1:0], 7'h70 + r[4:2], 4'h0);
      rf_op(1'b0, r[9] ? 6'h27 : 6'h34 + r[8:6], 4'h0);
      if (r[10])
        mem_op(1'b1, r[12:11], 7'h70 + r[15:13], r[19:16]);
      else
        rf_op(1'b1, r[20] ? 6'h27 : 6'h34 + r[23:21], r[27:24]);
      check_pins();
    end
    close_out();
  end
endmodule
`default_nettype wire
